// *** hw/acsc_chan_map.v ***
`timescale 1ns/10ps
`include "acsc_regs.vh"
// Maps a 4-bit channel code to the physical or internal channel selection
module acsc_chan_map (
	input  wire       special,
	input  wire [3:0] code,
	output reg  [4:0] sel,
	output reg        reserved
);
	// External map saturates at the top input; internal map has holes
	always @* begin
		sel      = `ACSC_SEL_RSVD;
		reserved = 1'b0;
		if (!special) begin
			if (code > `ACSC_CH_TOP)
				sel = {1'b0, `ACSC_CH_TOP};
			else
				sel = {1'b0, code};
		end else begin
			case (code)
			`ACSC_SP_PROBE: sel = `ACSC_SEL_PROBE;
			`ACSC_SP_REFH:  sel = `ACSC_SEL_REFH;
			`ACSC_SP_REFL:  sel = `ACSC_SEL_REFL;
			`ACSC_SP_MID:   sel = `ACSC_SEL_MID;
			default:        reserved = 1'b1;
			endcase
		end
	end
endmodule // acsc_chan_map

// *** hw/acsc_next_chan.v ***
`timescale 1ns/10ps
`include "acsc_regs.vh"
// Next channel code in multi-channel mode, with wrap handling
module acsc_next_chan (
	input  wire [3:0] cur,
	input  wire [3:0] wrap_limit,
	input  wire       wrapped,
	output reg  [3:0] next,
	output reg        wrap_now
);
	// Before the first wrap, a start above the limit runs up to the top input
	always @* begin
		wrap_now = 1'b0;
		next     = cur + 4'h1;
		if (cur == wrap_limit && (wrapped || cur <= wrap_limit)) begin
			wrap_now = 1'b1;
			next     = `ACSC_CH_ZERO;
		end else if (cur >= `ACSC_CH_TOP) begin
			wrap_now = 1'b1;
			next     = `ACSC_CH_ZERO;
		end
	end
endmodule // acsc_next_chan

// *** hw/acsc_regs.vh ***
`ifndef ACSC_REGS_VH
`define ACSC_REGS_VH
// Byte addresses: printed offset 0x5 is not a multiple of four, so index times four
`define ACSC_IDX_START      8'h05
`define ACSC_ADDR_START     8'h14
`define ACSC_ADDR_CFG       8'h20
`define ACSC_ADDR_STATUS    8'h24
`define ACSC_ADDR_CHAN      8'h28
// Start control fields
`define ACSC_BIT_SPECIAL    6
`define ACSC_BIT_CONT       5
`define ACSC_BIT_ACROSS     4
`define ACSC_START_MASK     8'h7F
`define ACSC_START_RESET    8'h00
// Configuration register fields
`define ACSC_CFG_ETRIG      8
`define ACSC_CFG_WRAP_LSB   4
`define ACSC_CFG_LEN_LSB    0
`define ACSC_CFG_RESET      32'h0000_0000
// Channel selection constants
`define ACSC_CH_TOP         4'h9
`define ACSC_CH_ZERO        4'h0
`define ACSC_LEN_MAX        4'hA
`define ACSC_SP_PROBE       4'h1
`define ACSC_SP_REFH        4'h4
`define ACSC_SP_REFL        4'h5
`define ACSC_SP_MID         4'h6
// Channel output encoding: bit 4 marks an internal channel
`define ACSC_SEL_PROBE      5'h11
`define ACSC_SEL_REFH       5'h14
`define ACSC_SEL_REFL       5'h15
`define ACSC_SEL_MID        5'h16
`define ACSC_SEL_RSVD       5'h1F
// Conversion timing and bus response codes
`define ACSC_CONV_CYCLES    8'h10
`define ACSC_BRESP_OKAY     2'b00
`define ACSC_BRESP_SLVERR   2'b10
`endif

// *** hw/acsc_top.v ***
`timescale 1ns/10ps
`include "acsc_regs.vh"
// Contract
// - any start write aborts, starts new sequence
// - with trigger, first write arms trigger starts
// - conversion start marks sampling phase begin
// - bit 6 selects internal channel map
// - bit 5 repeats sequences continuously
// - trigger mode ignores continuous; one sequence
// - single mode samples one channel throughout
// - multi mode walks seq_length channels
// - increment channel, wrap after wrap_limit
// - start above limit wraps 9 to 0
// - external codes above 9 select 9
// - internal codes 1,4,5,6; others reserved
// - start register readable, writable anytime
// - length code 0 or 10+ gives 10
// - counter zeroed at sequence start, end
module acsc_top #(
	parameter CONV_CYCLES = 8
) (
	input  wire        REF_CLK,
	input  wire        ARST_N,
	input  wire [7:0]  AWADDR,
	input  wire        AWVALID,
	output reg         AWREADY,
	input  wire [31:0] WDATA,
	input  wire [3:0]  WSTRB,
	input  wire        WVALID,
	output reg         WREADY,
	output reg  [1:0]  BRESP,
	output reg         BVALID,
	input  wire        BREADY,
	input  wire [7:0]  ARADDR,
	input  wire        ARVALID,
	output reg         ARREADY,
	output reg  [31:0] RDATA,
	output reg  [1:0]  RRESP,
	output reg         RVALID,
	input  wire        RREADY,
	input  wire        EXT_TRIGGER,
	output reg         SAMPLE_START,
	output reg  [4:0]  CHANNEL_SEL,
	output reg  [3:0]  CONV_COUNT,
	output reg         BUSY
);
	localparam ST_IDLE = 2'b00;
	localparam ST_CONV = 2'b01;
	localparam ST_NEXT = 2'b10;

	reg  [7:0]  start_ctrl;
	reg  [31:0] cfg;
	reg  [1:0]  state;
	reg  [3:0]  cur_code;
	reg  [3:0]  done_cnt;
	reg  [7:0]  tick;
	reg         wrapped;
	reg         armed;
	reg         aw_hold;
	reg         w_hold;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         trig_prev;
	wire        wr_fire;
	wire        start_wr;
	wire        trig_edge;
	wire        ext_trig_en;
	wire [3:0]  wrap_limit;
	wire [3:0]  len_code;
	reg  [3:0]  seq_len;
	wire [4:0]  map_sel;
	wire        map_rsvd;
	wire [3:0]  nxt_code;
	wire        wrap_now;
	wire        launch;

	assign ext_trig_en = cfg[`ACSC_CFG_ETRIG];
	assign wrap_limit  = cfg[`ACSC_CFG_WRAP_LSB+3:`ACSC_CFG_WRAP_LSB];
	assign len_code    = cfg[`ACSC_CFG_LEN_LSB+3:`ACSC_CFG_LEN_LSB];
	assign wr_fire     = aw_hold && w_hold && !BVALID;
	assign start_wr    = wr_fire && aw_addr == `ACSC_ADDR_START && w_strb[0];
	assign trig_edge   = EXT_TRIGGER && !trig_prev;
	// A trigger only counts once armed and when no software start collides
	assign launch      = start_wr ? !ext_trig_en : (armed && ext_trig_en && trig_edge && !BUSY);

	// Sequence length decode, saturating
	always @* begin
		if (len_code == 4'h0 || len_code >= `ACSC_LEN_MAX)
			seq_len = `ACSC_LEN_MAX;
		else
			seq_len = len_code;
	end

	acsc_chan_map u_map (
		.special  (start_ctrl[`ACSC_BIT_SPECIAL]),
		.code     (cur_code),
		.sel      (map_sel),
		.reserved (map_rsvd)
	);

	acsc_next_chan u_next (
		.cur        (cur_code),
		.wrap_limit (wrap_limit),
		.wrapped    (wrapped),
		.next       (nxt_code),
		.wrap_now   (wrap_now)
	);

	// AXI write address and data captured independently, in either order
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			BVALID  <= 1'b0;
			BRESP   <= `ACSC_BRESP_OKAY;
		end else begin
			AWREADY <= !aw_hold && !AWREADY && AWVALID;
			WREADY  <= !w_hold && !WREADY && WVALID;
			if (AWVALID && AWREADY) begin
				aw_hold <= 1'b1;
				aw_addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_hold <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				BVALID  <= 1'b1;
				case (aw_addr)
				`ACSC_ADDR_START, `ACSC_ADDR_CFG, `ACSC_ADDR_STATUS, `ACSC_ADDR_CHAN:
					BRESP <= `ACSC_BRESP_OKAY;
				default: BRESP <= `ACSC_BRESP_SLVERR;
				endcase
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// Register storage; start register writable in any state
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			start_ctrl <= `ACSC_START_RESET;
			cfg        <= `ACSC_CFG_RESET;
		end else if (wr_fire) begin
			if (start_wr)
				start_ctrl <= w_data[7:0] & `ACSC_START_MASK;
			if (aw_addr == `ACSC_ADDR_CFG) begin
				if (w_strb[0])
					cfg[7:0] <= w_data[7:0];
				if (w_strb[1])
					cfg[`ACSC_CFG_ETRIG] <= w_data[`ACSC_CFG_ETRIG];
			end
		end
	end

	// AXI read channel; one cycle to answer
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= `ACSC_BRESP_OKAY;
		end else begin
			ARREADY <= !RVALID && !ARREADY && ARVALID;
			if (ARVALID && ARREADY) begin
				RVALID <= 1'b1;
				RRESP  <= `ACSC_BRESP_OKAY;
				case (ARADDR)
				`ACSC_ADDR_START:  RDATA <= {24'h00_0000, start_ctrl};
				`ACSC_ADDR_CFG:    RDATA <= {23'h00_0000, cfg[8:0]};
				`ACSC_ADDR_STATUS: RDATA <= {26'h000_0000, armed, BUSY, CONV_COUNT};
				`ACSC_ADDR_CHAN:   RDATA <= {26'h000_0000, map_rsvd, CHANNEL_SEL};
				default: begin
					RDATA <= 32'h0000_0000;
					RRESP <= `ACSC_BRESP_SLVERR;
				end
				endcase
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// Sequencer: a start write aborts anything running; without trigger mode it restarts from its own code
	always @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state        <= ST_IDLE;
			cur_code     <= 4'h0;
			done_cnt     <= 4'h0;
			tick         <= 8'h00;
			wrapped      <= 1'b0;
			armed        <= 1'b0;
			trig_prev    <= 1'b0;
			SAMPLE_START <= 1'b0;
			CHANNEL_SEL  <= 5'h00;
			CONV_COUNT   <= 4'h0;
			BUSY         <= 1'b0;
		end else begin
			trig_prev    <= EXT_TRIGGER;
			SAMPLE_START <= 1'b0;
			if (start_wr)
				armed <= 1'b1;
			if (start_wr && !launch) begin
				state      <= ST_IDLE;
				BUSY       <= 1'b0;
				CONV_COUNT <= 4'h0;
			end else if (launch) begin
				// Code comes from the new write when one is in flight
				state        <= ST_CONV;
				BUSY         <= 1'b1;
				cur_code     <= start_wr ? w_data[3:0] : start_ctrl[3:0];
				wrapped      <= 1'b0;
				done_cnt     <= 4'h0;
				tick         <= 8'h00;
				CONV_COUNT   <= 4'h0;
				SAMPLE_START <= 1'b1;
			end else begin
				case (state)
				ST_IDLE: ;
				ST_CONV: begin
					CHANNEL_SEL <= map_sel;
					if (tick == CONV_CYCLES - 1) begin
						tick  <= 8'h00;
						state <= ST_NEXT;
					end else begin
						tick <= tick + 8'h01;
					end
				end
				ST_NEXT: begin
					if (done_cnt + 4'h1 >= seq_len) begin
						done_cnt   <= 4'h0;
						CONV_COUNT <= 4'h0;
						wrapped    <= 1'b0;
						cur_code   <= start_ctrl[3:0];
						// Trigger mode always runs one sequence only
						if (start_ctrl[`ACSC_BIT_CONT] && !ext_trig_en) begin
							state        <= ST_CONV;
							SAMPLE_START <= 1'b1;
						end else begin
							state <= ST_IDLE;
							BUSY  <= 1'b0;
						end
					end else begin
						done_cnt     <= done_cnt + 4'h1;
						CONV_COUNT   <= done_cnt + 4'h1;
						state        <= ST_CONV;
						SAMPLE_START <= 1'b1;
						if (start_ctrl[`ACSC_BIT_ACROSS]) begin
							cur_code <= nxt_code;
							if (wrap_now)
								wrapped <= 1'b1;
						end // else code held
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // acsc_top

// *** verif/acsc_properties.sv ***
`timescale 1ns/10ps
// Sequencer and bus checks, seen only from the top ports
module acsc_properties (
	input wire        REF_CLK,
	input wire        ARST_N,
	input wire        BVALID,
	input wire        BREADY,
	input wire        RVALID,
	input wire        RREADY,
	input wire [31:0] RDATA,
	input wire        SAMPLE_START,
	input wire [4:0]  CHANNEL_SEL,
	input wire [3:0]  CONV_COUNT,
	input wire        BUSY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	// A response must wait for its ready
	sequence b_wait;
		BVALID && !BREADY;
	endsequence
	busy_pulse_a: assert property (SAMPLE_START |-> BUSY)
		else $error("sample start while idle");
	// A start write may cut a conversion one cycle after its pulse
	pulse_one_a: assert property (SAMPLE_START |=> !SAMPLE_START || $rose(BVALID))
		else $error("sample start too long");
	count_idle_a: assert property (!BUSY |-> CONV_COUNT == 4'h0)
		else $error("count not zero when idle");
	count_max_a: assert property (CONV_COUNT <= 4'h9)
		else $error("count beyond ten conversions");
	seq_open_a: assert property ($rose(BUSY) |-> SAMPLE_START && CONV_COUNT == 4'h0)
		else $error("sequence opened wrongly");
	count_step_a: assert property (!$stable(CONV_COUNT) |-> SAMPLE_START || !BUSY)
		else $error("count moved without a conversion");
	chan_code_a: assert property (SAMPLE_START |=> CHANNEL_SEL <= 5'h09 || CHANNEL_SEL >= 5'h11)
		else $error("channel encoding out of range");
	b_hold_a: assert property (b_wait |=> BVALID)
		else $error("write response dropped");
	r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read response dropped");
endmodule // acsc_properties

bind acsc_top acsc_properties u_props (.REF_CLK, .ARST_N, .BVALID, .BREADY, .RVALID, .RREADY,
	.RDATA, .SAMPLE_START, .CHANNEL_SEL, .CONV_COUNT, .BUSY);

// *** verif/acsc_tb_top.sv ***
`timescale 1ns/10ps
`include "acsc_regs.vh"
module acsc_tb_top;
	reg         REF_CLK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, EXT_TRIGGER;
	reg  [7:0]  AWADDR, ARADDR, cur;
	reg  [31:0] WDATA, r;
	wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_START, BUSY;
	wire [1:0]  BRESP, RRESP;
	wire [31:0] RDATA;
	wire [4:0]  CHANNEL_SEL;
	wire [3:0]  CONV_COUNT;
	integer     bad_count, tests_run, seed, ign, p, k, t;
	reg  [8:0]  exq[$];
	reg  [8:0]  e;

	// Short conversions keep the run brief
	acsc_top #(.CONV_CYCLES(2)) DUT (.REF_CLK, .ARST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA,
		.WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
		.RDATA, .RRESP, .RVALID, .RREADY, .EXT_TRIGGER, .SAMPLE_START, .CHANNEL_SEL, .CONV_COUNT,
		.BUSY);

	initial begin
		REF_CLK = 0;
		forever #5 REF_CLK = ~REF_CLK;
	end

	task chk(input string n, input [31:0] x, input [31:0] g);
		tests_run++;
		if (x !== g) begin
			bad_count++;
			$display("Error %0s expected %h seen %h", n, x, g);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// A bound that runs out is a mismatch and ends the run
	task limit(input integer b);
		if (t >= b) begin
			bad_count++;
			$display("Error timeout expected %0d seen %0d", b - 1, t);
			test_done;
		end
	endtask

	task axi_w(input [7:0] a, input [31:0] d, input [1:0] x);
		@(posedge REF_CLK);
		{cur, AWADDR, WDATA} <= {a, a, d};
		{AWVALID, WVALID, BREADY} <= 3'b111;
		for (t = 0; t < 99 && !(BVALID && BREADY); t++) begin
			@(posedge REF_CLK);
			if (AWREADY) AWVALID <= 0;
			if (WREADY) WVALID <= 0;
		end
		limit(99);
		BREADY <= 0;
		chk("bresp", x, BRESP);
	endtask

	task axi_r(input [7:0] a, input [31:0] d, input [1:0] x);
		@(posedge REF_CLK);
		{ARADDR, ARVALID, RREADY} <= {a, 2'b11};
		for (t = 0; t < 99 && !(RVALID && RREADY); t++) begin
			@(posedge REF_CLK);
			if (ARREADY) ARVALID <= 0;
		end
		limit(99);
		RREADY <= 0;
		chk("rdata", d, RDATA);
		chk("rresp", x, RRESP);
	endtask

	function [4:0] sel(input s, input [3:0] c);
		if (!s) sel = c > 9 ? 5'h09 : {1'b0, c};
		else case (c)
			1: sel = 5'h11;
			4: sel = 5'h14;
			5: sel = 5'h15;
			6: sel = 5'h16;
			default: sel = 5'h1F;
		endcase
	endfunction

	task idle;
		for (t = 0; t < 999 && (exq.size() || BUSY); t++) @(posedge REF_CLK);
		repeat (3) @(posedge REF_CLK);
		chk("idle", 1, t < 999);
		limit(999);
	endtask

	// Model the channel walk, then start and read back
	task run(input [3:0] ln, input [3:0] wr, input [7:0] st);
		integer n, c, ab, j;
		n = (ln == 0 || ln > 9) ? 10 : ln;
		ign = 1;
		axi_w(`ACSC_ADDR_CFG, {24'h0, wr, ln}, 2'b00);
		exq.delete();
		for (j = 0; j < n * (st[5] ? 2 : 1); j++) begin
			if (j % n == 0) begin
				c = st[3:0];
				ab = c > wr;
			end
			exq.push_back({4'(j % n), sel(st[6], 4'(c))});
			if (st[4] && (c == 9 || (c == wr && !ab))) {c, ab} = 0;
			else if (st[4]) c++;
		end
		axi_w(`ACSC_ADDR_START, {24'h0, st}, 2'b00);
		axi_r(`ACSC_ADDR_START, {24'h0, st & 8'h7F}, 2'b00);
		if (st[5]) begin
			for (t = 0; t < 999 && exq.size(); t++) @(posedge REF_CLK);
			limit(999);
			ign = 1;
			chk("busy", 1, BUSY);
		end
		else idle;
		$display("run %h done", st);
	endtask

	// Each conversion: count at the pulse, channel a cycle later
	always @(posedge REF_CLK) begin
		if (p) chk("chan", e[4:0], CHANNEL_SEL);
		p = 0;
		if (SAMPLE_START && BVALID && cur == `ACSC_ADDR_START) ign = 0;
		if (SAMPLE_START && !ign && !exq.size()) chk("extra", 0, 1);
		else if (SAMPLE_START && !ign) begin
			e = exq.pop_front();
			chk("count", e[8:5], CONV_COUNT);
			p = 1;
		end
	end

	initial begin
		seed      = 32'h0000_7024;
		bad_count = 0;
		tests_run = 0;
		{ign, p, cur} = 0;
		{ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, EXT_TRIGGER} = 0;
		{AWADDR, ARADDR, WDATA} = 0;
		repeat (20) @(posedge REF_CLK);
		ARST_N <= 1;
		axi_r(`ACSC_ADDR_START, 0, 2'b00);
		axi_r(8'h30, 0, 2'b10);
		axi_w(8'h30, 32'hFFFF_FFFF, 2'b10);
		for (k = 0; k < 32; k++) begin
			r = $random(seed);
			run(4'h1, 4'h9, {r[0], k[4], 2'b00, k[3:0]});
		end
		for (k = 0; k < 6; k++) begin
			r = $random(seed);
			run(r[3:0], 4'(r[7:4] % 9 + 1), {r[8], 3'b001, 4'(r[15:12] % 10)});
		end
		run(4'h0, 4'h3, 8'h17);
		run(4'hC, 4'h2, 8'h05);
		run(4'h3, 4'h5, 8'h34);
		run(4'h2, 4'h5, 8'h02);
		axi_w(`ACSC_ADDR_CFG, 32'h0000_0192, 2'b00);
		ign = 0;
		axi_w(`ACSC_ADDR_START, 32'h0000_0023, 2'b00);
		repeat (10) @(posedge REF_CLK);
		chk("armed", 0, BUSY);
		for (k = 0; k < 2; k++) begin
			exq = '{9'h003, 9'h023};
			@(posedge REF_CLK) EXT_TRIGGER <= 1;
			@(posedge REF_CLK) EXT_TRIGGER <= 0;
			idle;
			repeat (20) @(posedge REF_CLK);
			chk("one sequence", 0, BUSY);
			$display("trigger %0d done", k);
		end
		test_done;
	end
endmodule // acsc_tb_top
